// file: verilog/hbg_defines.svh
`ifndef HBG_DEFINES_SVH
`define HBG_DEFINES_SVH

// ==========================================================
// Timing base
`define HBG_CLK_PERIOD_NS 50

// ==========================================================
// Dead time
`define HBG_DT_W 8
`define HBG_DT_MIN_NS 80
`define HBG_DT_MIN_CYC \
  ((`HBG_DT_MIN_NS + `HBG_CLK_PERIOD_NS - 1) / `HBG_CLK_PERIOD_NS)

// ==========================================================
// Short-circuit shutdown delay
`define HBG_SC_W 8
`define HBG_SC_TIME_NS 11000
`define HBG_SC_CYC (`HBG_SC_TIME_NS / `HBG_CLK_PERIOD_NS)

// ==========================================================
// Reset values
`define HBG_GATE_RST 3'h0
`define HBG_STAGE_RST 6'h00

`endif

// file: verilog/hbg_pkg.sv
package hbg_pkg;

  // ========================================================
  // Command lines from the controller, one bit per leg
  typedef struct packed {
    logic [2:0] low_side_command_in;
    logic [2:0] high_side_command_in_n;
  } hbg_cmd_t;

  // ========================================================
  // Gate drive outputs, one bit per leg
  typedef struct packed {
    logic [2:0] low_gate_out;
    logic [2:0] high_gate_out;
  } hbg_gate_t;

  // Per-stage vector: bits 2:0 low stages, 5:3 high stages
  typedef logic [5:0] hbg_stage_t;

endpackage : hbg_pkg

// file: verilog/hbg_gate_logic.sv
`timescale 1ns/10ps
`include "hbg_defines.svh"

module hbg_gate_logic (
  input  wire logic              clk_i,                   // 20 MHz clock
  input  wire logic              resetn_i,                // Async reset
  input  wire hbg_pkg::hbg_cmd_t cmd_i,                   // Command pins
  input  wire logic              enable_threshold_line_i, // Enable level
  input  wire logic [7:0]        dead_time_set_pin_i,     // Dead time code
  input  wire hbg_pkg::hbg_stage_t uv_warn_i,             // UV warning
  input  wire hbg_pkg::hbg_stage_t uv_shut_i,             // UV shutdown
  input  wire hbg_pkg::hbg_stage_t sc_detect_i,           // Desat sense
  output logic                   pump_step_o,             // Pump pulse
  output hbg_pkg::hbg_gate_t     gate_o,                  // Gate drives
  output logic                   fault_o,                 // Error pin
  output logic                   sc_error_o               // SC latched
);
  import hbg_pkg::*;

  // ========================================================
  // Helpers

  // Dead time load value, never below the minimum setting
  // Codes under the minimum would let partner gates overlap
  function automatic logic [`HBG_DT_W-1:0] dt_load(
    input logic [`HBG_DT_W-1:0] code
  );
    logic [`HBG_DT_W-1:0] min_v;
    min_v = `HBG_DT_W'(`HBG_DT_MIN_CYC);
    dt_load = (code < min_v) ? min_v : code;
  endfunction : dt_load

  // Any change between two samples of a line
  // Either direction counts, for resync and edge views
  function automatic logic edge_of(
    input logic now_v,
    input logic old_v
  );
    edge_of = now_v ^ old_v;
  endfunction : edge_of

  // Stage-ordered view of a command word, high lines on top
  function automatic hbg_stage_t stage_view(
    input hbg_cmd_t c
  );
    stage_view = {c.high_side_command_in_n, c.low_side_command_in};
  endfunction : stage_view

  // ========================================================
  // Input synchronisers
  hbg_cmd_t             cmd_s1_q;
  hbg_cmd_t             cmd_s2_q;
  hbg_cmd_t             cmd_old_q;
  logic                 en_s1_q;
  logic                 en_s2_q;
  logic [`HBG_DT_W-1:0] dt_s1_q;
  logic [`HBG_DT_W-1:0] dt_s2_q;
  hbg_stage_t           uvw_s1_q;
  hbg_stage_t           uvw_s2_q;
  hbg_stage_t           uvs_s1_q;
  hbg_stage_t           uvs_s2_q;
  hbg_stage_t           scd_s1_q;
  hbg_stage_t           scd_s2_q;

  // Two flops on every pin before any logic reads it
  // The dead time code is a static level but still a pin,
  // so it is synchronised like the command lines.
  // cmd_old_q keeps the previous settled command for edges.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_s1_q  <= '0;
      cmd_s2_q  <= '0;
      cmd_old_q <= '0;
      en_s1_q   <= 1'b0;
      en_s2_q   <= 1'b0;
      dt_s1_q   <= '0;
      dt_s2_q   <= '0;
      uvw_s1_q  <= `HBG_STAGE_RST;
      uvw_s2_q  <= `HBG_STAGE_RST;
      uvs_s1_q  <= `HBG_STAGE_RST;
      uvs_s2_q  <= `HBG_STAGE_RST;
      scd_s1_q  <= `HBG_STAGE_RST;
      scd_s2_q  <= `HBG_STAGE_RST;
    end else begin
      cmd_s1_q  <= cmd_i;
      cmd_s2_q  <= cmd_s1_q;
      cmd_old_q <= cmd_s2_q;
      en_s1_q   <= enable_threshold_line_i;
      en_s2_q   <= en_s1_q;
      dt_s1_q   <= dead_time_set_pin_i;
      dt_s2_q   <= dt_s1_q;
      uvw_s1_q  <= uv_warn_i;
      uvw_s2_q  <= uvw_s1_q;
      uvs_s1_q  <= uv_shut_i;
      uvs_s2_q  <= uvs_s1_q;
      scd_s1_q  <= sc_detect_i;
      scd_s2_q  <= scd_s1_q;
    end
  end

  // Stage-ordered views of the synchronised commands
  hbg_stage_t cmd_now;
  hbg_stage_t cmd_old;
  hbg_stage_t cmd_edge;

  assign cmd_now = stage_view(cmd_s2_q);
  assign cmd_old = stage_view(cmd_old_q);

  // Edge flags per stage
  always_comb begin
    for (int s = 0; s < 6; s++) begin
      cmd_edge[s] = edge_of(cmd_now[s], cmd_old[s]);
    end
  end

  // ========================================================
  // Leg control: lockout, dead time, base gate state
  logic [2:0]           tgt_lo_q;
  logic [2:0]           tgt_hi_q;
  logic [2:0]           tgt_lo_d;
  logic [2:0]           tgt_hi_d;
  logic [2:0]           base_lo_q;
  logic [2:0]           base_hi_q;
  logic [2:0]           base_lo_d;
  logic [2:0]           base_hi_d;
  logic [`HBG_DT_W-1:0] cnt_q [3];
  logic [`HBG_DT_W-1:0] cnt_d [3];

  // Targets follow the commands unless both would be on;
  // the base state is the gate level before stage masking.
  // A gate may only rise with its leg counter idle and its
  // partner already off, so two gates can never overlap.
  always_comb begin
    logic want_lo;
    logic want_hi;
    logic quiet;
    want_lo = 1'b0;
    want_hi = 1'b0;
    quiet   = 1'b0;
    for (int i = 0; i < 3; i++) begin
      want_lo = cmd_s2_q.low_side_command_in[i];
      want_hi = ~cmd_s2_q.high_side_command_in_n[i];
      // Old target is kept, so a glitch cannot flip the leg
      // both-on request ignored
      if (want_lo && want_hi) begin
        tgt_lo_d[i] = tgt_lo_q[i];
        tgt_hi_d[i] = tgt_hi_q[i];
      end else begin
        tgt_lo_d[i] = want_lo;
        tgt_hi_d[i] = want_hi;
      end
      quiet = (cnt_q[i] == '0);
      base_lo_d[i] = tgt_lo_d[i] &
                     (base_lo_q[i] | (quiet & ~base_hi_q[i]));
      base_hi_d[i] = tgt_hi_d[i] &
                     (base_hi_q[i] | (quiet & ~base_lo_q[i]));
      // Checked last so nothing above can override it
      // disabled leg held off
      if (!en_s2_q) begin
        base_lo_d[i] = 1'b0;
        base_hi_d[i] = 1'b0;
      end
      // Load one below the code: the partner rises on the edge
      // after the count reaches zero, so the gap between the
      // falling and the rising gate is the code, but never less than the minimum.
      // reload per-leg down-counter
      // only turn-off reloads, close edges merge
      if ((base_lo_q[i] & ~base_lo_d[i]) |
          (base_hi_q[i] & ~base_hi_d[i])) begin
        cnt_d[i] = dt_load(dt_s2_q) - `HBG_DT_W'(1);
      end else if (!quiet) begin
        cnt_d[i] = cnt_q[i] - `HBG_DT_W'(1);
      end else begin
        cnt_d[i] = cnt_q[i];
      end
    end
  end

  // Leg state registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tgt_lo_q  <= `HBG_GATE_RST;
      tgt_hi_q  <= `HBG_GATE_RST;
      base_lo_q <= `HBG_GATE_RST;
      base_hi_q <= `HBG_GATE_RST;
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      tgt_lo_q  <= tgt_lo_d;
      tgt_hi_q  <= tgt_hi_d;
      base_lo_q <= base_lo_d;
      base_hi_q <= base_hi_d;
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  // ========================================================
  // Stage supervision: resync, short-circuit, outputs
  hbg_stage_t           rsy_q;
  hbg_stage_t           rsy_d;
  hbg_stage_t           gate_q;
  hbg_stage_t           gate_d;
  logic [`HBG_SC_W-1:0] sc_cnt_q;
  logic [`HBG_SC_W-1:0] sc_cnt_d;
  logic                 sc_lat_q;
  logic                 sc_lat_d;
  logic                 fault_q;
  logic                 fault_d;
  logic                 pump_q;
  logic                 pump_d;

  // Next state of the supervision flops; a shut stage stays
  // masked until its own pin moves, so a recovered supply
  // cannot restart a stale half-period on its own.
  always_comb begin
    logic sc_act;
    sc_act = 1'b0;
    // pending until next command edge, set wins
    rsy_d = uvs_s2_q | (rsy_q & ~cmd_edge);
    // stage off while shut or pending
    // warning does not gate the outputs
    gate_d = {base_hi_d, base_lo_d} & ~uvs_s2_q & ~rsy_d;
    // latched fault turns all six off
    if (sc_lat_q) begin
      gate_d = `HBG_STAGE_RST;
    end
    sc_act = |(scd_s2_q & gate_q & ~uvs_s2_q);
    // Only driven, unshut stages count; any gap restarts the
    // count, so a brief desaturation never latches.
    // count persisting short-circuit
    if (!en_s2_q || !sc_act) begin
      sc_cnt_d = '0;
    end else if (sc_cnt_q != `HBG_SC_W'(`HBG_SC_CYC)) begin
      sc_cnt_d = sc_cnt_q + `HBG_SC_W'(1);
    end else begin
      sc_cnt_d = sc_cnt_q;
    end
    // latch on expiry; disable clears it
    sc_lat_d = en_s2_q &
               (sc_lat_q |
                (sc_act &&
                 sc_cnt_q == `HBG_SC_W'(`HBG_SC_CYC - 1)));
    fault_d = (|uvw_s2_q) | (|uvs_s2_q) | sc_lat_d;
    // A static low command gives no steps at all
    // pump steps on low-side turn-on only
    pump_d = |(cmd_now[2:0] & ~cmd_old[2:0]);
  end

  // Supervision registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsy_q    <= `HBG_STAGE_RST;
      gate_q   <= `HBG_STAGE_RST;
      sc_cnt_q <= '0;
      sc_lat_q <= 1'b0;
      fault_q  <= 1'b0;
      pump_q   <= 1'b0;
    end else begin
      rsy_q    <= rsy_d;
      gate_q   <= gate_d;
      sc_cnt_q <= sc_cnt_d;
      sc_lat_q <= sc_lat_d;
      fault_q  <= fault_d;
      pump_q   <= pump_d;
    end
  end

  // ========================================================
  // Outputs straight from flops
  // so no pin glitches while the next state settles
  assign gate_o.low_gate_out  = gate_q[2:0];
  assign gate_o.high_gate_out = gate_q[5:3];
  assign fault_o              = fault_q;
  assign sc_error_o           = sc_lat_q;
  assign pump_step_o          = pump_q;

endmodule : hbg_gate_logic

// file: test/hbg_gate_assertions.sv
`timescale 1ns/10ps
// Port checker for the gate logic
module hbg_gate_assertions (
  input wire logic               clk_i,                   // Clock
  input wire logic               resetn_i,                // Reset
  input wire hbg_pkg::hbg_cmd_t  cmd_i,                   // Commands
  input wire logic               enable_threshold_line_i, // Enable
  input wire logic [7:0]         dead_time_set_pin_i,     // Dead time
  input wire hbg_pkg::hbg_stage_t uv_warn_i,              // UV warn
  input wire hbg_pkg::hbg_stage_t uv_shut_i,              // UV shut
  input wire hbg_pkg::hbg_stage_t sc_detect_i,            // SC sense
  input wire logic               pump_step_o,             // Pump
  input wire hbg_pkg::hbg_gate_t gate_o,                  // Gates
  input wire logic               fault_o,                 // Fault
  input wire logic               sc_error_o               // SC latch
);
  logic [5:0] gv;
  // Gates in stage order
  assign gv = {gate_o.high_gate_out, gate_o.low_gate_out};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================
  // Properties
  a_no_shoot: assert property (
    (gate_o.low_gate_out & gate_o.high_gate_out) == 3'h0)
    else $error("leg on");
  a_enable_off: assert property (
    !enable_threshold_line_i [*4] |-> gate_o == 6'h00 && !sc_error_o)
    else $error("gate on while off");
  a_pump_idle: assert property (
    $stable(cmd_i.low_side_command_in) [*6] |-> !pump_step_o)
    else $error("pump");
  a_pump_step: assert property (
    $rose(cmd_i.low_side_command_in[0]) |-> ##[1:5] pump_step_o)
    else $error("no pump");
  a_fault_warn: assert property (
    |uv_warn_i [*5] |-> fault_o) else $error("no warn");
  a_sc_gates_off: assert property (
    sc_error_o ##1 sc_error_o |-> gate_o == 6'h00) else $error("sc gates");
  a_sc_fault: assert property (
    sc_error_o |-> ##[0:1] fault_o) else $error("sc fault");
  for (genvar i = 0; i < 3; i++) begin : g_leg
    a_dead_lh: assert property (
      $fell(gv[i]) |-> !gv[i+3] [*2]) else $error("dead time");
    a_dead_hl: assert property (
      $fell(gv[i+3]) |-> !gv[i] [*2]) else $error("dead time");
  end
  for (genvar s = 0; s < 6; s++) begin : g_stage
    a_shut_gate_off: assert property (
      uv_shut_i[s] [*5] |-> !gv[s]) else $error("shut gate");
  end
  c_sc: cover property ($rose(sc_error_o));
  c_pump: cover property ($rose(pump_step_o));
  c_dead: cover property ($fell(gv[0]));
endmodule : hbg_gate_assertions
bind hbg_gate_logic hbg_gate_assertions u_chk (.clk_i(clk_i),
  .resetn_i(resetn_i), .cmd_i(cmd_i), .gate_o(gate_o),
  .enable_threshold_line_i(enable_threshold_line_i),
  .dead_time_set_pin_i(dead_time_set_pin_i), .uv_warn_i(uv_warn_i),
  .uv_shut_i(uv_shut_i), .sc_detect_i(sc_detect_i),
  .pump_step_o(pump_step_o), .fault_o(fault_o), .sc_error_o(sc_error_o));

// file: test/hbg_mcu_model.sv
`timescale 1ns/10ps
// Controller model: registers line requests onto command pins
module hbg_mcu_model (
  input  wire logic       clk_i,    // Clock
  input  wire logic       en_req_i, // Enable request
  input  wire logic       comb_i,   // One line per leg
  input  wire logic [2:0] line_i,   // Combined lines
  input  wire logic [2:0] low_i,    // Low commands
  input  wire logic [2:0] high_n_i, // High commands
  output hbg_pkg::hbg_cmd_t cmd_o,  // Command pins
  output logic            en_o      // Enable level
);
  hbg_pkg::hbg_cmd_t cmd_q = '0;   // Pin register
  logic              en_q  = 1'b0; // Enable register
  assign en_o  = en_q;
  assign cmd_o = cmd_q;
  always @(posedge clk_i) begin
    en_q <= en_req_i;
    cmd_q.low_side_command_in <= comb_i ? line_i : low_i;
    cmd_q.high_side_command_in_n <= comb_i ? line_i : high_n_i;
  end
endmodule : hbg_mcu_model

// file: test/testbench.sv
`timescale 1ns/10ps
// Self-checking bench for the gate logic
module testbench;
  import hbg_pkg::*;
  logic clk_i = 1'b0, resetn_i = 1'b0, en_req = 1'b0, comb = 1'b1;
  logic [2:0] line = 3'h0, low = 3'h0, high_n = 3'h7;
  logic [7:0] dt = 8'h05;
  hbg_stage_t uv_warn = 6'h00, uv_shut = 6'h00, sc_det = 6'h00;
  hbg_cmd_t cmd;
  hbg_gate_t gate;
  logic en, pump, fault, sc_err, hi, lo;
  int fail_count = 0, compares = 0, cyc = 0, pumps = 0, n;
  // Model flop, two sync flops and the gate flop
  localparam int PIPE = 4;
  always #25 clk_i = ~clk_i;
  hbg_mcu_model mcu (.clk_i(clk_i), .en_req_i(en_req), .comb_i(comb),
    .line_i(line), .low_i(low), .high_n_i(high_n), .cmd_o(cmd), .en_o(en));
  hbg_gate_logic dut (.clk_i(clk_i), .resetn_i(resetn_i), .cmd_i(cmd),
    .enable_threshold_line_i(en), .dead_time_set_pin_i(dt),
    .uv_warn_i(uv_warn), .uv_shut_i(uv_shut), .sc_detect_i(sc_det),
    .pump_step_o(pump), .gate_o(gate), .fault_o(fault), .sc_error_o(sc_err));
  // Pump pulse count and hang limit
  always @(posedge clk_i) begin
    if (pump === 1'b1) pumps++;
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      summarize;
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick
  // Cycles from gate f falling to gate r rising
  task automatic meas(input int f, input int r);
    for (n = 0; gate[f] !== 1'b0 && n < 30; n++) tick(1);
    for (n = 0; gate[r] !== 1'b1 && n < 30; n++) tick(1);
  endtask : meas
  task automatic summarize;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // ==========================================================
  // Scenarios
  task automatic t_off;
    repeat (4) begin
      @(posedge clk_i) line <= 3'h7;
      tick(6);
      chk(gate, 0);
      @(posedge clk_i) line <= 3'h0;
      tick(6);
    end
    chk(pumps, 4);
    @(posedge clk_i) begin comb <= 1'b0; high_n <= 3'h0; end
    tick(8);
    chk(pumps, 4);
    @(posedge clk_i) comb <= 1'b1;
  endtask : t_off
  task automatic t_comb;
    @(posedge clk_i) line <= 3'h1;
    tick(10);
    chk(gate, 9'h0E);
    @(posedge clk_i) line <= 3'h0;
    meas(3, 0);
    chk(n, dt);
    tick(6);
    @(posedge clk_i) line <= 3'h1;
    meas(0, 3);
    chk(n, dt);
    hi = 1'b0;
    lo = 1'b0;
    @(posedge clk_i) line <= 3'h0;
    @(posedge clk_i);
    @(posedge clk_i) line <= 3'h1;
    repeat (20) begin
      tick(1);
      hi |= gate[0];
      lo |= !gate[3];
    end
    chk({hi, lo}, 2'b01);
  endtask : t_comb
  // Separate lines: close edges merge, wide ones pass
  task automatic t_sep;
    @(posedge clk_i) begin comb <= 1'b0; low <= 3'h1; high_n <= 3'h1; end
    tick(10);
    @(posedge clk_i) low <= 3'h0;
    @(posedge clk_i);
    @(posedge clk_i) high_n <= 3'h0;
    meas(3, 0);
    chk(n, dt);
    @(posedge clk_i) high_n <= 3'h1;
    tick(10);
    @(posedge clk_i) low <= 3'h1;
    meas(0, 3);
    chk(n, PIPE);
    tick(4);
  endtask : t_sep
  task automatic t_both;
    @(posedge clk_i) begin comb <= 1'b0; low <= 3'h2; high_n <= 3'h3; end
    tick(14);
    chk(gate, 9'h14);
    @(posedge clk_i) low <= 3'h6;
    tick(10);
    chk(gate, 9'h14);
  endtask : t_both
  task automatic t_uv;
    @(posedge clk_i) begin comb <= 1'b1; line <= 3'h0; uv_warn <= 6'h08; end
    tick(15);
    chk({fault, gate}, 9'h47);
    @(posedge clk_i) line <= 3'h7;
    tick(15);
    chk(gate, 9'h38);
    @(posedge clk_i) begin line <= 3'h0; uv_shut <= 6'h08; end
    tick(15);
    chk(gate, 9'h06);
    @(posedge clk_i) uv_shut <= 6'h00;
    tick(10);
    chk(gate, 9'h06);
    @(posedge clk_i) line <= 3'h1;
    tick(12);
    @(posedge clk_i) begin line <= 3'h0; uv_warn <= 6'h00; end
    tick(15);
    chk(gate, 9'h07);
  endtask : t_uv
  task automatic t_sc;
    @(posedge clk_i) begin sc_det <= 6'h08; uv_shut <= 6'h08; end
    tick(260);
    chk(sc_err, 0);
    // stage resyncs on its own line edge, then drives high
    @(posedge clk_i) begin uv_shut <= 6'h00; line <= 3'h1; end
    tick(12);
    @(posedge clk_i) line <= 3'h0;
    for (n = 0; sc_err !== 1'b1 && n < 300; n++) tick(1);
    chk(n > 215 && n < 235, 1);
    tick(2);
    chk({fault, gate}, 9'h40);
    @(posedge clk_i) begin sc_det <= 6'h00; en_req <= 1'b0; end
    tick(8);
    chk(sc_err, 0);
  endtask : t_sc
  initial begin
    tick(11);
    @(posedge clk_i) resetn_i <= 1'b1;
    t_off;
    @(posedge clk_i) en_req <= 1'b1;
    tick(6);
    t_comb;
    t_sep;
    t_both;
    t_uv;
    t_sc;
    summarize;
  end
endmodule : testbench
